// >>> hw/lmsc_params.svh
// Constants for the LO mode and sync control block
`ifndef LMSC_PARAMS_SVH
`define LMSC_PARAMS_SVH
`define LMSC_REG_DEV_CFG 7'h02
`define LMSC_REG_LO_CFG 7'h20
`define LMSC_REG_TUNE2 7'h21
`define LMSC_REG_TUNE4 7'h22
`define LMSC_DEV_CFG_RST 8'h00
`define LMSC_LO_CFG_RST 8'h00
`define LMSC_TUNE_RST 8'h00
`define LMSC_BIT_SHUTDOWN 1
`define LMSC_BIT_BYPASS 4
`define LMSC_BIT_OFS_EN 2
`define LMSC_MODE_MSB 1
`define LMSC_MODE_LSB 0
`define LMSC_TUNE_MASK 8'h1f
`define LMSC_INSTR_LAST 4'h7
`define LMSC_FRAME_LAST 4'hf
`define LMSC_FRAME_BITS 5'h10
`define LMSC_DATA_FIRST 5'h08
`define LMSC_OFS_DIV_W 4
`define LMSC_SCK_HALF 8'h04
`define LMSC_AXI_CMD 4'h0
`define LMSC_AXI_STATUS 4'h4
`define LMSC_AXI_PINS 4'h8
`define LMSC_RESP_OKAY 2'b00
`define LMSC_RESP_SLVERR 2'b10
`endif

// >>> hw/lmsc_pkg.sv
// Types shared by the serial port ends and the LO path control
package lmsc_pkg;
	typedef enum logic [2:0] {
		LMSC_MODE_DIV2 = 3'h0,
		LMSC_MODE_MUL1 = 3'h1,
		LMSC_MODE_MUL2 = 3'h2,
		LMSC_MODE_MUL4 = 3'h3,
		LMSC_MODE_BYPASS = 3'h4
	} lmsc_route_t;
	typedef enum logic [4:0] {
		LMSC_D_IDLE = 5'b00001,
		LMSC_D_INSTR = 5'b00010,
		LMSC_D_WDATA = 5'b00100,
		LMSC_D_RDATA = 5'b01000,
		LMSC_D_DONE = 5'b10000
	} lmsc_dev_st_t;
	typedef enum logic [2:0] {
		LMSC_H_IDLE = 3'b001,
		LMSC_H_SHIFT = 3'b010,
		LMSC_H_END = 3'b100
	} lmsc_host_st_t;
endpackage : lmsc_pkg

// >>> hw/lmsc_if.sv
// Pin level interface between the serial controller and the device
`timescale 1ns/1ps
interface lmsc_if;
	logic en_o;
	logic en_oe;
	logic sync_o;
	logic sync_oe;
	logic sck_o;
	logic sck_oe;
	logic cs_n_o;
	logic cs_n_oe;
	logic host_sdio_o;
	logic host_sdio_oe;
	logic dev_sdio_o;
	logic dev_sdio_oe;
	logic en;
	logic sync;
	logic sck;
	logic cs_n;
	logic sdio;
	// Undriven pins fall back to their pull levels
	assign en = en_oe ? en_o : 1'b0; // RULE2
	assign sync = sync_oe ? sync_o : 1'b0; // RULE6
	assign sck = sck_oe ? sck_o : 1'b0; // RULE6
	assign cs_n = cs_n_oe ? cs_n_o : 1'b1; // RULE8
	// One shared data wire; host wins if both drive, as a series resistor would let it
	assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b0); // RULE9
	modport dev (input en, input sync, input sck, input cs_n, input sdio,
		output dev_sdio_o, output dev_sdio_oe);
	modport host (output en_o, output en_oe, output sync_o, output sync_oe, output sck_o,
		output sck_oe, output cs_n_o, output cs_n_oe, output host_sdio_o,
		output host_sdio_oe, input sdio);
endinterface : lmsc_if

// >>> hw/lmsc_device.sv
// Device end: serial register port, shutdown, sync divider reset and LO path select
// Operation
// RULE1 - Shutdown when shutdown bit set or enable low
// RULE2 - Floating enable reads as deasserted
// RULE3 - Sync falling edge resets LO and offset dividers
// RULE4 - System delivers sync before next LO edge
// RULE5 - Sync works before any LO clock runs
// RULE6 - Floating sync and serial clock read low
// RULE7 - Port active only while chip select low
// RULE8 - Floating chip select reads high, port off
// RULE9 - One shared data line, three wires total
// RULE10 - Device output released during controller writes
// RULE11 - Bypass plus four modes chosen by LO register
// RULE12 - Bypass routes LO direct, disables everything else
// RULE13 - Mode 0 halves LO, offset optional
// RULE14 - Mode 1 skips dividers, keeps offset mixer
// RULE15 - Software prefers bypass over multiply by one
// RULE16 - Mode 2 doubles, filters with first tune code
// RULE17 - Mode 3 doubles twice with both tune codes
// RULE18 - Instruction byte then data byte, MSB first
`timescale 1ns/1ps
`include "lmsc_params.svh"
module lmsc_device (
	input wire logic aclk, // 250 MHz clock
	input wire logic aresetn, // Synchronous reset, active low
	lmsc_if.dev pins, // Serial and control pins
	input wire logic local_osc_in_pos, // LO input, positive leg
	input wire logic local_osc_in_neg, // LO input, negative leg
	input wire logic offset_tone_in_pos, // Offset input, positive leg
	input wire logic offset_tone_in_neg, // Offset input, negative leg
	output logic shutdown, // Device shut down
	output lmsc_pkg::lmsc_route_t lo_route, // Selected LO path
	output logic multipliers_en, // Doublers running
	output logic dividers_en, // Dividers running
	output logic offset_tone_path_en, // Offset mixer path running
	output logic [4:0] doubler_filter_tune, // First band-pass tune code
	output logic [4:0] quadrupler_filter_tune, // Second band-pass tune code
	output logic divider_reset, // One-cycle divider reset pulse
	output logic lo_div_out, // Halved LO
	output logic offset_div_out // Divided offset tone
);
	typedef struct packed {
		lmsc_pkg::lmsc_dev_st_t st;
		logic sck_q;
		logic sync_q;
		logic lo_q;
		logic of_q;
		logic [3:0] bit_q;
		logic [6:0] sh_q;
		logic [6:0] addr_q;
		logic [7:0] tx_q;
		logic sdo_q;
		logic oe_q;
		logic [7:0] dev_cfg_q;
		logic [7:0] lo_cfg_q;
		logic [7:0] tune2_q;
		logic [7:0] tune4_q;
		logic rst_pulse_q;
		logic div2_q;
		logic [`LMSC_OFS_DIV_W-1:0] ofcnt_q;
	} lmsc_dev_state_t;

	lmsc_dev_state_t s_r;
	lmsc_dev_state_t s_nxt;

	function automatic logic [7:0] lmsc_reg_read(input lmsc_dev_state_t s, input logic [6:0] a);
		case (a)
			`LMSC_REG_DEV_CFG: lmsc_reg_read = s.dev_cfg_q;
			`LMSC_REG_LO_CFG: lmsc_reg_read = s.lo_cfg_q;
			`LMSC_REG_TUNE2: lmsc_reg_read = s.tune2_q;
			`LMSC_REG_TUNE4: lmsc_reg_read = s.tune4_q;
			default: lmsc_reg_read = 8'h00;
		endcase
	endfunction : lmsc_reg_read

	function automatic lmsc_pkg::lmsc_route_t lmsc_route(input logic [7:0] c);
		if (c[`LMSC_BIT_BYPASS]) begin
			lmsc_route = lmsc_pkg::LMSC_MODE_BYPASS;
		end else begin
			lmsc_route = lmsc_pkg::lmsc_route_t'({1'b0, c[`LMSC_MODE_MSB:`LMSC_MODE_LSB]});
		end
	endfunction : lmsc_route

	logic en_off;
	logic sck_rise;
	logic sck_fall;
	logic sync_fall;
	logic lo_lvl;
	logic of_lvl;
	lmsc_pkg::lmsc_route_t route;
	logic [7:0] rx_byte;

	assign lo_lvl = local_osc_in_pos & ~local_osc_in_neg;
	assign of_lvl = offset_tone_in_pos & ~offset_tone_in_neg;
	assign sck_rise = pins.sck & ~s_r.sck_q; // RULE6
	assign sck_fall = ~pins.sck & s_r.sck_q;
	assign sync_fall = ~pins.sync & s_r.sync_q; // RULE3
	assign rx_byte = {s_r.sh_q, pins.sdio}; // RULE18
	assign en_off = ~pins.en; // RULE2
	assign route = lmsc_route(s_r.lo_cfg_q); // RULE11

	always_comb begin
		s_nxt = s_r;
		s_nxt.sck_q = pins.sck;
		s_nxt.sync_q = pins.sync;
		s_nxt.lo_q = lo_lvl;
		s_nxt.of_q = of_lvl;
		s_nxt.rst_pulse_q = sync_fall;
		if (pins.cs_n) begin
			// Deselected: frame abandoned, data line released
			s_nxt.st = lmsc_pkg::LMSC_D_IDLE; // RULE7 RULE8
			s_nxt.bit_q = 4'h0;
			s_nxt.oe_q = 1'b0; // RULE10
		end else begin
			case (s_r.st)
				lmsc_pkg::LMSC_D_IDLE: begin
					s_nxt.st = lmsc_pkg::LMSC_D_INSTR; // RULE7
					if (sck_rise) begin
						s_nxt.sh_q = rx_byte[6:0];
						s_nxt.bit_q = 4'h1;
					end
				end
				lmsc_pkg::LMSC_D_INSTR: begin
					if (sck_rise) begin
						s_nxt.sh_q = rx_byte[6:0];
						s_nxt.bit_q = s_r.bit_q + 4'h1;
						if (s_r.bit_q == `LMSC_INSTR_LAST) begin
							// Read flag is the first bit, address the next seven
							s_nxt.addr_q = rx_byte[6:0]; // RULE18
							s_nxt.tx_q = lmsc_reg_read(s_r, rx_byte[6:0]);
							s_nxt.st = rx_byte[7] ? lmsc_pkg::LMSC_D_RDATA
								: lmsc_pkg::LMSC_D_WDATA;
						end
					end
				end
				lmsc_pkg::LMSC_D_WDATA: begin
					s_nxt.oe_q = 1'b0; // RULE10
					if (sck_rise) begin
						s_nxt.sh_q = rx_byte[6:0];
						s_nxt.bit_q = s_r.bit_q + 4'h1;
						if (s_r.bit_q == `LMSC_FRAME_LAST) begin
							s_nxt.st = lmsc_pkg::LMSC_D_DONE;
							case (s_r.addr_q)
								`LMSC_REG_DEV_CFG: s_nxt.dev_cfg_q = rx_byte; // RULE1
								`LMSC_REG_LO_CFG: s_nxt.lo_cfg_q = rx_byte; // RULE11
								`LMSC_REG_TUNE2: s_nxt.tune2_q = rx_byte & `LMSC_TUNE_MASK; // RULE16
								`LMSC_REG_TUNE4: s_nxt.tune4_q = rx_byte & `LMSC_TUNE_MASK; // RULE17
								default: s_nxt.dev_cfg_q = s_r.dev_cfg_q;
							endcase
						end
					end
				end
				lmsc_pkg::LMSC_D_RDATA: begin
					// Drive on falls so the controller samples a settled bit on rises
					if (sck_fall) begin
						s_nxt.oe_q = 1'b1; // RULE9 RULE18
						s_nxt.sdo_q = s_r.tx_q[7];
						s_nxt.tx_q = {s_r.tx_q[6:0], 1'b0};
					end
					if (sck_rise) begin
						s_nxt.bit_q = s_r.bit_q + 4'h1;
						if (s_r.bit_q == `LMSC_FRAME_LAST) begin
							s_nxt.st = lmsc_pkg::LMSC_D_DONE;
						end
					end
				end
				lmsc_pkg::LMSC_D_DONE: begin
					// Extra clocks are ignored; line let go on the next fall
					if (sck_fall) begin
						s_nxt.oe_q = 1'b0;
					end
				end
				default: begin
					s_nxt.st = lmsc_pkg::LMSC_D_IDLE;
				end
			endcase
		end
		// Divider state; sync works whether or not the inputs are toggling
		if (sync_fall) begin
			s_nxt.div2_q = 1'b0; // RULE3 RULE5
			s_nxt.ofcnt_q = '0; // RULE3 RULE5
		end else begin
			if (dividers_en && lo_lvl && !s_r.lo_q) begin
				s_nxt.div2_q = ~s_r.div2_q; // RULE13
			end
			if (offset_tone_path_en && of_lvl && !s_r.of_q) begin
				s_nxt.ofcnt_q = s_r.ofcnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '{st: lmsc_pkg::LMSC_D_IDLE, dev_cfg_q: `LMSC_DEV_CFG_RST,
				lo_cfg_q: `LMSC_LO_CFG_RST, tune2_q: `LMSC_TUNE_RST,
				tune4_q: `LMSC_TUNE_RST, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign shutdown = s_r.dev_cfg_q[`LMSC_BIT_SHUTDOWN] | en_off; // RULE1
	assign lo_route = route;
	// Bypass shuts the doublers, dividers and offset path
	assign multipliers_en = ~shutdown & (route == lmsc_pkg::LMSC_MODE_MUL2
		|| route == lmsc_pkg::LMSC_MODE_MUL4); // RULE12 RULE16 RULE17
	assign dividers_en = ~shutdown & (route == lmsc_pkg::LMSC_MODE_DIV2); // RULE12 RULE13
	assign offset_tone_path_en = ~shutdown & (route != lmsc_pkg::LMSC_MODE_BYPASS)
		& s_r.lo_cfg_q[`LMSC_BIT_OFS_EN]; // RULE12 RULE13 RULE14
	assign doubler_filter_tune = s_r.tune2_q[4:0]; // RULE16
	assign quadrupler_filter_tune = s_r.tune4_q[4:0]; // RULE17
	assign divider_reset = s_r.rst_pulse_q; // RULE3
	assign lo_div_out = s_r.div2_q; // RULE13
	assign offset_div_out = s_r.ofcnt_q[`LMSC_OFS_DIV_W-1];
	assign pins.dev_sdio_o = s_r.sdo_q;
	assign pins.dev_sdio_oe = s_r.oe_q; // RULE10
endmodule : lmsc_device

// >>> hw/lmsc_ctrl.sv
// Controller end: AXI4-Lite registers driving the three-wire serial port
`timescale 1ns/1ps
`include "lmsc_params.svh"
module lmsc_ctrl (
	input wire logic aclk, // 250 MHz clock
	input wire logic aresetn, // Synchronous reset, active low
	lmsc_if.host pins, // Serial and control pins
	input wire logic [3:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [3:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready // Read data ready
);
	typedef struct packed {
		lmsc_pkg::lmsc_host_st_t st;
		logic aw_q;
		logic [3:0] awaddr_q;
		logic w_q;
		logic [31:0] wdata_q;
		logic [3:0] wstrb_q;
		logic bvalid_q;
		logic [1:0] bresp_q;
		logic rvalid_q;
		logic [1:0] rresp_q;
		logic [31:0] rdata_q;
		logic [15:0] sh_q;
		logic [4:0] bit_q;
		logic [7:0] div_q;
		logic rd_q;
		logic [7:0] rx_q;
		logic sck_q;
		logic cs_n_q;
		logic sdo_q;
		logic oe_q;
		logic en_q;
		logic sync_q;
		logic float_q;
	} lmsc_host_state_t;

	lmsc_host_state_t s_r;
	lmsc_host_state_t s_nxt;
	logic half_done;

	assign half_done = (s_r.div_q == `LMSC_SCK_HALF - 8'h01);

	always_comb begin
		s_nxt = s_r;
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_q = 1'b1;
			s_nxt.awaddr_q = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_q = 1'b1;
			s_nxt.wdata_q = s_axi_wdata;
			s_nxt.wstrb_q = s_axi_wstrb;
		end
		if (s_r.bvalid_q && s_axi_bready) begin
			s_nxt.bvalid_q = 1'b0;
		end
		if (s_r.aw_q && s_r.w_q && !s_r.bvalid_q) begin
			s_nxt.aw_q = 1'b0;
			s_nxt.w_q = 1'b0;
			s_nxt.bvalid_q = 1'b1;
			s_nxt.bresp_q = `LMSC_RESP_OKAY;
			case (s_r.awaddr_q)
				`LMSC_AXI_CMD: begin
					// A command while a frame runs is dropped
					if (s_r.st == lmsc_pkg::LMSC_H_IDLE && s_r.wstrb_q != 4'h0) begin
						s_nxt.st = lmsc_pkg::LMSC_H_SHIFT;
						s_nxt.sh_q = {s_r.wdata_q[8], s_r.wdata_q[6:0], s_r.wdata_q[23:16]};
						s_nxt.rd_q = s_r.wdata_q[8];
						s_nxt.bit_q = 5'h00;
						s_nxt.div_q = 8'h00;
						s_nxt.cs_n_q = 1'b0; // RULE7
						s_nxt.sck_q = 1'b0;
						s_nxt.sdo_q = s_r.wdata_q[8];
						s_nxt.oe_q = 1'b1;
					end
				end
				`LMSC_AXI_PINS: begin
					if (s_r.wstrb_q[0]) begin
						s_nxt.en_q = s_r.wdata_q[0];
						s_nxt.sync_q = s_r.wdata_q[1];
						s_nxt.float_q = s_r.wdata_q[2];
					end
				end
				`LMSC_AXI_STATUS: s_nxt.bresp_q = `LMSC_RESP_OKAY;
				default: s_nxt.bresp_q = `LMSC_RESP_SLVERR;
			endcase
		end
		if (s_r.rvalid_q && s_axi_rready) begin
			s_nxt.rvalid_q = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.rvalid_q = 1'b1;
			s_nxt.rresp_q = `LMSC_RESP_OKAY;
			case (s_axi_araddr)
				`LMSC_AXI_CMD: s_nxt.rdata_q = {24'h000000, s_r.sh_q[15:8]};
				`LMSC_AXI_STATUS: s_nxt.rdata_q = {16'h0000, s_r.rx_q, 7'h00,
					s_r.st != lmsc_pkg::LMSC_H_IDLE};
				`LMSC_AXI_PINS: s_nxt.rdata_q = {29'h00000000, s_r.float_q, s_r.sync_q, s_r.en_q};
				default: begin
					s_nxt.rdata_q = 32'h00000000;
					s_nxt.rresp_q = `LMSC_RESP_SLVERR;
				end
			endcase
		end
		if (s_r.st != lmsc_pkg::LMSC_H_IDLE) begin
			s_nxt.div_q = half_done ? 8'h00 : s_r.div_q + 8'h01;
		end
		case (s_r.st)
			lmsc_pkg::LMSC_H_IDLE: begin
				s_nxt.cs_n_q = (s_nxt.st == lmsc_pkg::LMSC_H_IDLE) ? 1'b1 : s_nxt.cs_n_q;
			end
			lmsc_pkg::LMSC_H_SHIFT: begin
				if (half_done && !s_r.sck_q) begin
					s_nxt.sck_q = 1'b1;
					s_nxt.bit_q = s_r.bit_q + 5'h01;
					if (s_r.rd_q && s_r.bit_q >= `LMSC_DATA_FIRST) begin
						s_nxt.rx_q = {s_r.rx_q[6:0], pins.sdio}; // RULE18
					end
				end else if (half_done) begin
					s_nxt.sck_q = 1'b0;
					if (s_r.bit_q == `LMSC_FRAME_BITS) begin
						s_nxt.st = lmsc_pkg::LMSC_H_END;
						s_nxt.oe_q = 1'b0;
					end else begin
						s_nxt.sh_q = {s_r.sh_q[14:0], 1'b0};
						s_nxt.sdo_q = s_r.sh_q[14];
						// Let go of the line before the device turns it round
						s_nxt.oe_q = !(s_r.rd_q && s_r.bit_q >= `LMSC_DATA_FIRST); // RULE10
					end
				end
			end
			lmsc_pkg::LMSC_H_END: begin
				if (half_done) begin
					s_nxt.cs_n_q = 1'b1; // RULE7
					s_nxt.st = lmsc_pkg::LMSC_H_IDLE;
				end
			end
			default: s_nxt.st = lmsc_pkg::LMSC_H_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '{st: lmsc_pkg::LMSC_H_IDLE, cs_n_q: 1'b1, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready = !s_r.aw_q;
	assign s_axi_wready = !s_r.w_q;
	assign s_axi_bvalid = s_r.bvalid_q;
	assign s_axi_bresp = s_r.bresp_q;
	assign s_axi_arready = !s_r.rvalid_q;
	assign s_axi_rvalid = s_r.rvalid_q;
	assign s_axi_rresp = s_r.rresp_q;
	assign s_axi_rdata = s_r.rdata_q;
	assign pins.en_o = s_r.en_q;
	assign pins.en_oe = !s_r.float_q; // RULE2
	assign pins.sync_o = s_r.sync_q;
	assign pins.sync_oe = !s_r.float_q; // RULE6
	assign pins.sck_o = s_r.sck_q;
	// Clock and select let go between frames; the pull levels keep the port idle
	assign pins.sck_oe = (s_r.st != lmsc_pkg::LMSC_H_IDLE); // RULE6
	assign pins.cs_n_o = s_r.cs_n_q;
	assign pins.cs_n_oe = (s_r.st != lmsc_pkg::LMSC_H_IDLE); // RULE8
	assign pins.host_sdio_o = s_r.sdo_q; // RULE9
	assign pins.host_sdio_oe = s_r.oe_q; // RULE10
endmodule : lmsc_ctrl

// >>> test/lmsc_monitor.sv
// Checker on the serial pins and the LO path outputs
`timescale 1ns/1ps
module lmsc_monitor (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic en, // Enable pin
	input wire logic sync, // Sync pin
	input wire logic sck, // Serial clock
	input wire logic cs_n, // Chip select
	input wire logic host_sdio_oe, // Host drives data
	input wire logic dev_sdio_oe, // Device drives data
	input wire logic shutdown, // Shut down
	input wire lmsc_pkg::lmsc_route_t lo_route, // LO path
	input wire logic multipliers_en, // Doublers on
	input wire logic dividers_en, // Dividers on
	input wire logic offset_tone_path_en, // Offset path on
	input wire logic divider_reset // Divider reset pulse
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_sync_fall;
		sync ##1 !sync;
	endsequence
	sequence s_lead_in;
		!sck [*4] ##1 sck;
	endsequence
	a_sync_pulse: assert property (s_sync_fall |-> ##1 divider_reset)
		else $error("no divider reset after sync fall");
	a_pulse_cause: assert property (divider_reset |-> $past(sync, 2) && !$past(sync))
		else $error("divider reset without sync fall");
	a_pulse_single: assert property (divider_reset |=> !divider_reset)
		else $error("divider reset longer than one cycle");
	a_frame_lead: assert property ($fell(cs_n) |-> s_lead_in)
		else $error("bad serial clock lead in");
	a_sck_framed: assert property (sck |-> !cs_n)
		else $error("serial clock outside frame");
	a_dev_framed: assert property (dev_sdio_oe |-> !cs_n)
		else $error("device drives data while deselected");
	a_no_clash: assert property (host_sdio_oe |-> !dev_sdio_oe)
		else $error("both ends drive data");
	a_en_low_off: assert property (!en [*3] |-> shutdown)
		else $error("running with enable low");
	a_bypass_off: assert property (lo_route == lmsc_pkg::LMSC_MODE_BYPASS
		|-> !(multipliers_en || dividers_en || offset_tone_path_en))
		else $error("bypass leaves a path running");
	a_div_mode: assert property (dividers_en |-> lo_route == lmsc_pkg::LMSC_MODE_DIV2 && !shutdown)
		else $error("dividers on outside halving mode");
	a_mul1_plain: assert property (lo_route == lmsc_pkg::LMSC_MODE_MUL1
		|-> !multipliers_en && !dividers_en)
		else $error("multiply by one uses doublers");
endmodule : lmsc_monitor

// >>> test/tb_top.sv
// Testbench joining controller and device over the serial pins
`timescale 1ns/1ps
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d;
	logic lo_in = 1'b0;
	logic shutdown, multipliers_en, dividers_en, offset_tone_path_en, divider_reset, lo_div_out;
	lmsc_pkg::lmsc_route_t lo_route;
	logic [4:0] dft, qft;
	logic ofd;
	logic [7:0] cfg [5] = '{8'h04, 8'h05, 8'h06, 8'h03, 8'h14};
	logic [5:0] exm [5] = '{6'b000011, 6'b001001, 6'b010101, 6'b011100, 6'b100000};
	int num_errors = 0, n_checks = 0, n_pulse = 0, n0 = 0;
	always #2 aclk = ~aclk;
	always @(posedge aclk) if (divider_reset === 1'b1) n_pulse <= n_pulse + 1;
	lmsc_if pins_if();
	lmsc_ctrl lmsc_ctrl_i (.aclk, .aresetn, .pins(pins_if), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	lmsc_device lmsc_device_i (.aclk, .aresetn, .pins(pins_if), .local_osc_in_pos(lo_in),
		.local_osc_in_neg(1'b0), .offset_tone_in_pos(lo_in), .offset_tone_in_neg(1'b0),
		.shutdown, .lo_route, .multipliers_en, .dividers_en, .offset_tone_path_en,
		.doubler_filter_tune(dft), .quadrupler_filter_tune(qft), .divider_reset, .lo_div_out,
		.offset_div_out(ofd));
	lmsc_monitor lmsc_monitor_i (.aclk, .aresetn, .en(pins_if.en), .sync(pins_if.sync),
		.sck(pins_if.sck), .cs_n(pins_if.cs_n), .host_sdio_oe(pins_if.host_sdio_oe),
		.dev_sdio_oe(pins_if.dev_sdio_oe), .shutdown, .lo_route, .multipliers_en,
		.dividers_en, .offset_tone_path_en, .divider_reset);
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic hung(input int k);
		if (k >= 300) begin
			num_errors++;
			$display("BAD %0t wait ran out", $time);
			complete_run();
		end
	endtask : hung
	task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && k < 300);
		hung(k);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
		int k;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && k < 300);
		hung(k);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axr
	// Whole serial frame; result byte lands in d[15:8]
	task automatic spi(input logic rd, input logic [6:0] a, input logic [7:0] v);
		int k;
		axw(4'h0, {8'h00, v, 7'h00, rd, 1'b0, a}, r);
		k = 0;
		do begin
			axr(4'h4, d, r);
			k++;
		end while (d[0] !== 1'b0 && k < 300);
		hung(k);
	endtask : spi
	task automatic lo_pulse();
		@(posedge aclk);
		lo_in <= 1'b1;
		repeat (4) @(posedge aclk);
		lo_in <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask : lo_pulse
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(shutdown, 1'b1, "shutdown at reset");
		spi(1'b1, 7'h20, 8'h00);
		chk(d[15:8], 8'h00, "lo cfg reset");
		$display("test reset done");
		// Sync with no LO running yet
		axw(4'h8, 32'h2, r);
		axw(4'h8, 32'h0, r);
		axr(4'h8, d, r);
		axr(4'h4, d, r);
		chk(n_pulse, 1, "early sync pulses");
		$display("test early sync done");
		axw(4'h8, 32'h1, r);
		spi(1'b0, 7'h02, 8'h02);
		chk(shutdown, 1'b1, "shutdown bit set");
		spi(1'b0, 7'h02, 8'h00);
		chk(shutdown, 1'b0, "shutdown bit clear");
		$display("test shutdown done");
		for (int i = 0; i < 5; i++) begin
			spi(1'b0, 7'h20, cfg[i]);
			chk({lo_route, multipliers_en, dividers_en, offset_tone_path_en}, exm[i], "lo path");
			spi(1'b1, 7'h20, 8'h00);
			chk(d[15:8], cfg[i], "lo cfg readback");
		end
		spi(1'b0, 7'h21, 8'hff);
		chk(dft, 5'h1f, "first tune");
		spi(1'b1, 7'h21, 8'h00);
		chk(d[15:8], 8'h1f, "first tune readback");
		spi(1'b0, 7'h22, 8'hea);
		chk(qft, 5'h0a, "second tune");
		$display("test lo modes done");
		// Halving mode: sync must pull the divider back to a known phase
		spi(1'b0, 7'h20, 8'h00);
		lo_pulse();
		chk(lo_div_out, 1'b1, "halved lo toggles");
		axw(4'h8, 32'h3, r);
		axw(4'h8, 32'h1, r);
		axr(4'h4, d, r);
		chk(lo_div_out, 1'b0, "divider after sync");
		lo_pulse();
		chk(lo_div_out, 1'b1, "divider restarts");
		// Offset counter: eight edges set its top bit, sync clears it
		spi(1'b0, 7'h20, 8'h04);
		repeat (8) lo_pulse();
		chk(ofd, 1'b1, "offset divider counts");
		axw(4'h8, 32'h3, r);
		axw(4'h8, 32'h1, r);
		axr(4'h4, d, r);
		chk(ofd, 1'b0, "offset divider after sync");
		$display("test sync divider done");
		axw(4'hc, 32'h1, r);
		chk(r, 2'b10, "unmapped write");
		axr(4'hc, d, r);
		chk(r, 2'b10, "unmapped read resp");
		chk(d, 32'h0, "unmapped read data");
		// Let go of enable and sync: both must read low
		axw(4'h8, 32'h3, r);
		n0 = n_pulse;
		axw(4'h8, 32'h7, r);
		axr(4'h8, d, r);
		chk(d, 32'h7, "pins readback");
		chk(shutdown, 1'b1, "floating enable");
		chk(n_pulse, n0 + 1, "floating sync reads low");
		axw(4'h8, 32'h0, r);
		axr(4'h8, d, r);
		chk(shutdown, 1'b1, "enable dropped");
		$display("test bus errors and enable done");
		complete_run();
	end
endmodule : tb_top
